// File: logic/swc_params.svh
// offsets, field positions, reset values and constants of the sleep and wake-up controller
`ifndef SWC_PARAMS_SVH
`define SWC_PARAMS_SVH
`define SWC_CTRL_OFS 8'h00
`define SWC_STAT_OFS 8'h04
`define SWC_FLAG_OFS 8'h08
`define SWC_STAT_ASLEEP_BIT 0
`define SWC_STAT_WDTWAKE_BIT 1
`define SWC_STAT_PD_BIT 3
`define SWC_STAT_TO_BIT 4
`define SWC_CTRL_RST 8'h00
`define SWC_FLAG_RST 4'h0
`define SWC_PD_RST 1'b1
`define SWC_TO_RST 1'b1
`define SWC_IRQ_VECTOR 13'h0004
`define SWC_RESP_OKAY 2'h0
`define SWC_RESP_SLVERR 2'h2
`endif

// File: logic/swc_pkg.sv
// types shared by the sleep and wake-up controller
package swc_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_ASLEEP, ST_RESUME, ST_VECTOR} swc_state_e;
  // one bit per wake-capable interrupt source
  typedef struct packed {
    logic adc;
    logic timer;
    logic port_chg;
    logic ext;
  } swc_irq_s;
  // software control word
  typedef struct packed {
    logic ad_rc;
    logic tmr_async;
    swc_irq_s en;
    logic global_interrupt_enable;
    logic wdt_en;
  } swc_ctrl_s;
  typedef enum logic [1:0] {SEL_CTRL, SEL_STAT, SEL_FLAG, SEL_NONE} swc_sel_e;
endpackage

// File: logic/swc_sleep_ctrl.sv
// sleep and wake-up controller with AXI4-Lite control registers
//
// Contract
// - executing sleep clears the power-down flag, sets the time-out flag, clears an enabled watchdog and stops the oscillator.
// - in power-down every I/O pin keeps the drive state it had before sleep.
// - power-down ends on a master clear, an enabled watchdog time-out or an enabled interrupt.
// - master clear in power-down gives a full reset, every other wake resumes execution.
// - the power-down flag is set at power-up and cleared only by executing sleep.
// - a watchdog time-out that wakes the device clears the time-out flag.
// - of the clocked peripherals, only the timer in asynchronous mode and the converter on its RC clock may wake the device.
// - phase clocks stop in power-down so clocked peripherals raise no interrupts.
// - while sleep executes the next instruction at pc plus one is prefetched.
// - an interrupt wakes only with its own enable set, whatever the global enable.
// - after interrupt wake the next instruction runs, then with global enable set a branch to 0004h.
// - sleep with an enabled flag already pending is a no-operation that changes no flag or watchdog.
// - an interrupt during or after sleep lets sleep complete and then wakes at once.
// - on vectored wake the pc takes the vector and the causing flags read as set.
`timescale 1ns/1ps
`include "swc_params.svh"
module swc_sleep_ctrl #(
  parameter int PC_W = 13,
  parameter int IO_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic sleep_exec_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic master_clear_pin_b_in,
  input wire logic wdt_timeout_in,
  input wire swc_pkg::swc_irq_s irq_src_in,
  input wire logic [IO_W-1:0] io_out_in,
  input wire logic [IO_W-1:0] io_oe_b_in,
  output logic [IO_W-1:0] io_out_out,
  output logic [IO_W-1:0] io_oe_b_out,
  output logic osc_drive_en_out,
  output logic core_clk_en_out,
  output logic phase_clk_en_out,
  output logic wdt_clear_out,
  output logic full_reset_out,
  output logic resume_out,
  output logic [PC_W-1:0] prefetch_addr_out,
  output logic pc_load_out,
  output logic [PC_W-1:0] pc_value_out
);
  swc_pkg::swc_state_e state_q, state_d;
  swc_pkg::swc_ctrl_s ctrl_q;
  swc_pkg::swc_irq_s flag_q, flag_d, set_ok, flag_clr;
  logic pd_q, to_q, wdt_wake_q, vec_q, clk_run_q;
  logic pending, wake_wdt;
  logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;

  function automatic swc_pkg::swc_sel_e swc_decode(input logic [7:0] addr);
    if (addr == `SWC_CTRL_OFS) begin
      return swc_pkg::SEL_CTRL;
    end else if (addr == `SWC_STAT_OFS) begin
      return swc_pkg::SEL_STAT;
    end else if (addr == `SWC_FLAG_OFS) begin
      return swc_pkg::SEL_FLAG;
    end else begin
      return swc_pkg::SEL_NONE;
    end
  endfunction

  swc_wake_qual u_wake (
    .ctrl_in(ctrl_q),
    .flag_in(flag_q),
    .asleep_in(state_q == swc_pkg::ST_ASLEEP),
    .wdt_timeout_in(wdt_timeout_in),
    .set_ok_out(set_ok),
    .pending_out(pending),
    .wake_wdt_out(wake_wdt)
  );

  // bus write path: address and data taken in either order
  wire aw_take = s_axi_awvalid_in & awready_q;
  wire w_take = s_axi_wvalid_in & wready_q;
  wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
  wire swc_pkg::swc_sel_e wsel = swc_decode(aw_addr_q);
  wire aw_full_d = (aw_full_q | aw_take) & ~do_wr;
  wire w_full_d = (w_full_q | w_take) & ~do_wr;
  wire bvalid_d = do_wr | (bvalid_q & ~s_axi_bready_in);
  wire wr_ctrl = do_wr & (wsel == swc_pkg::SEL_CTRL) & w_strb_q[0];
  wire wr_flag = do_wr & (wsel == swc_pkg::SEL_FLAG) & w_strb_q[0];
  wire ar_take = s_axi_arvalid_in & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready_in);
  wire swc_pkg::swc_sel_e rsel = swc_decode(s_axi_araddr_in);
  wire [31:0] stat_word = {27'h0, to_q, pd_q, 1'b0, wdt_wake_q, state_q == swc_pkg::ST_ASLEEP};
  wire [31:0] rd_word = (rsel == swc_pkg::SEL_CTRL) ? {24'h0, ctrl_q} :
                        (rsel == swc_pkg::SEL_STAT) ? stat_word :
                        (rsel == swc_pkg::SEL_FLAG) ? {28'h0, flag_q} : 32'h0;

  // causing flags stay set; a new event beats a write-one clear
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_flag
    assign flag_clr[gi] = wr_flag & w_data_q[gi];
    assign flag_d[gi] = (irq_src_in[gi] & set_ok[gi]) | (flag_q[gi] & ~flag_clr[gi]);
  end

  wire run = state_q == swc_pkg::ST_RUN;
  wire asleep = state_q == swc_pkg::ST_ASLEEP;
  // pending enabled flag turns sleep into a no-operation
  wire enter = run & sleep_exec_in & ~pending;
  wire master_clear_pin = asleep & ~master_clear_pin_b_in;
  wire wake_w = asleep & master_clear_pin_b_in & wake_wdt;
  // flag raised during sleep wakes on the next cycle
  wire wake_i = asleep & master_clear_pin_b_in & ~wake_wdt & pending;

  always_comb begin
    state_d = state_q;
    case (state_q)
      swc_pkg::ST_RUN: begin
        if (enter) begin
          state_d = swc_pkg::ST_ASLEEP;
        end
      end
      // hold until a wake or reset event
      swc_pkg::ST_ASLEEP: begin
        if (master_clear_pin) begin
          state_d = swc_pkg::ST_RUN;
        end else if (wake_w | wake_i) begin
          state_d = swc_pkg::ST_RESUME;
        end
      end
      swc_pkg::ST_RESUME: begin
        state_d = vec_q ? swc_pkg::ST_VECTOR : swc_pkg::ST_RUN;
      end
      default: begin
        state_d = swc_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bresp_q <= `SWC_RESP_OKAY;
      rdata_q <= 32'h0;
      rresp_q <= `SWC_RESP_OKAY;
    end else begin
      if (aw_take) aw_addr_q <= s_axi_awaddr_in;
      if (w_take) w_data_q <= s_axi_wdata_in;
      if (w_take) w_strb_q <= s_axi_wstrb_in;
      if (do_wr) bresp_q <= (wsel == swc_pkg::SEL_NONE) ? `SWC_RESP_SLVERR : `SWC_RESP_OKAY;
      if (ar_take) rdata_q <= rd_word;
      if (ar_take) rresp_q <= (rsel == swc_pkg::SEL_NONE) ? `SWC_RESP_SLVERR : `SWC_RESP_OKAY;
    end
  end

  // status register is read-only; writes to it are accepted and dropped
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= `SWC_CTRL_RST;
      flag_q <= `SWC_FLAG_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= w_data_q[7:0];
      flag_q <= flag_d;
    end
  end

  // power-down flag set at power-up, cleared only by sleep
  // flags change on real sleep entry
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pd_q <= `SWC_PD_RST;
      to_q <= `SWC_TO_RST;
      wdt_wake_q <= 1'b0;
    end else begin
      if (enter) pd_q <= 1'b0;
      if (enter) to_q <= 1'b1;
      else if (wake_w) to_q <= 1'b0;
      if (enter) wdt_wake_q <= 1'b0;
      else if (wake_w) wdt_wake_q <= 1'b1;
    end
  end

  // watchdog clear pulse and oscillator stop
  // phase and core clocks follow the oscillator
  // master clear in power-down gives a full reset pulse
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= swc_pkg::ST_RUN;
      clk_run_q <= 1'b1;
      wdt_clear_out <= 1'b0;
      full_reset_out <= 1'b0;
      vec_q <= 1'b0;
    end else begin
      state_q <= state_d;
      clk_run_q <= (state_d != swc_pkg::ST_ASLEEP);
      wdt_clear_out <= enter & ctrl_q.wdt_en;
      full_reset_out <= master_clear_pin;
      if (wake_i | wake_w) vec_q <= wake_i & ctrl_q.global_interrupt_enable;
    end
  end

  // prefetch address captured as sleep executes
  // resume at next instruction, then vector if global enable was set
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prefetch_addr_out <= '0;
      resume_out <= 1'b0;
      pc_load_out <= 1'b0;
      pc_value_out <= '0;
    end else begin
      if (enter) prefetch_addr_out <= pc_in + 1'b1;
      resume_out <= (state_d == swc_pkg::ST_RESUME);
      pc_load_out <= (state_d == swc_pkg::ST_VECTOR);
      if (state_d == swc_pkg::ST_VECTOR) pc_value_out <= PC_W'(`SWC_IRQ_VECTOR);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      io_out_out <= '0;
      io_oe_b_out <= '1;
    end else if (!asleep) begin
      io_out_out <= io_out_in;
      io_oe_b_out <= io_oe_b_in;
    end
  end

  assign osc_drive_en_out = clk_run_q;
  assign core_clk_en_out = clk_run_q;
  assign phase_clk_en_out = clk_run_q;
  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  sleep_entry_a: assert property (enter |=> !pd_q && to_q && !osc_drive_en_out && asleep)
    else $error("sleep entry did not update flags or stop oscillator");
  wdt_clear_a: assert property (enter && ctrl_q.wdt_en |=> wdt_clear_out ##1 !wdt_clear_out)
    else $error("watchdog clear pulse missing");
  io_hold_a: assert property (asleep && $past(asleep) |-> $stable(io_out_out) && $stable(io_oe_b_out))
    else $error("pins changed during power-down");
  master_clear_pin_reset_a: assert property (master_clear_pin |=> full_reset_out && run)
    else $error("master clear in power-down gave no full reset");
  pd_cause_a: assert property ($fell(pd_q) |-> $past(enter))
    else $error("power-down flag cleared without sleep");
  to_wdt_a: assert property (wake_w |=> !to_q && resume_out ##1 !pc_load_out && run)
    else $error("watchdog wake handled wrongly");
  gate_timer_a: assert property (asleep && !ctrl_q.tmr_async |-> !set_ok.timer)
    else $error("synchronous timer allowed to set flag in power-down");
  clocks_off_a: assert property (asleep |-> !phase_clk_en_out && !core_clk_en_out)
    else $error("clocks running in power-down");
  prefetch_a: assert property (enter |=> prefetch_addr_out == $past(pc_in) + 1'b1)
    else $error("prefetch address not pc plus one");
  vector_a: assert property (wake_i && ctrl_q.global_interrupt_enable |=> resume_out ##1 pc_load_out && pc_value_out == 13'h0004)
    else $error("vectored wake sequence wrong");
  nop_sleep_a: assert property (run && sleep_exec_in && pending |=> run && $stable(pd_q) && !wdt_clear_out)
    else $error("sleep with pending flag was not a no-operation");

  sleep_cycle_c: cover property (enter ##[1:50] wake_i);
  wdt_wake_c: cover property (enter ##[1:50] wake_w);
  vector_c: cover property (pc_load_out);
  master_clear_pin_c: cover property (full_reset_out);
endmodule // swc_sleep_ctrl

// File: logic/swc_wake_qual.sv
// wake qualification: which sources may set flags and which events end power-down
`timescale 1ns/1ps
module swc_wake_qual (
  input wire swc_pkg::swc_ctrl_s ctrl_in,
  input wire swc_pkg::swc_irq_s flag_in,
  input wire logic asleep_in,
  input wire logic wdt_timeout_in,
  output swc_pkg::swc_irq_s set_ok_out,
  output logic pending_out,
  output logic wake_wdt_out
);
  // clocked peripherals muted in power-down, only self-clocked ones pass
  assign set_ok_out.ext = 1'b1;
  assign set_ok_out.port_chg = 1'b1;
  assign set_ok_out.timer = ~asleep_in | ctrl_in.tmr_async;
  assign set_ok_out.adc = ~asleep_in | ctrl_in.ad_rc;
  // individual enable needed, global enable ignored
  assign pending_out = |(flag_in & ctrl_in.en);
  assign wake_wdt_out = ctrl_in.wdt_en & wdt_timeout_in;
endmodule // swc_wake_qual

// File: sim/swc_sleep_ctrl_tb.sv
// self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ps
`include "swc_params.svh"
module swc_sleep_ctrl_tb;
  localparam logic [7:0] a_ct = `SWC_CTRL_OFS, a_st = `SWC_STAT_OFS, a_fl = `SWC_FLAG_OFS;
  localparam logic [1:0] ok = `SWC_RESP_OKAY, se = `SWC_RESP_SLVERR;
  logic clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic slp = 1'b0, wdt_req = 1'b0, master_clear_pin_req = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, io_o = 8'h00, io_e = 8'hFF, io_oo, io_eo;
  logic [31:0] wd = 32'h0, rd;
  logic [12:0] pcv = 13'h0000, pfa, pcval;
  logic [3:0] irq_req = 4'h0;
  logic awr, wr_rdy, bv, arr, rv, master_clear_pin_b, wdt_to, osc, cclk, pclk, wclr, frst, res, pld;
  logic [1:0] br, rr;
  swc_pkg::swc_irq_s irq;
  int n_errors = 0, num_checks = 0;
  wire [3:0] ev = {frst, pld, res, wclr};
  always #4 clk = ~clk;
  swc_src_model i_src (.clk_in(clk), .rst_b_in(rst_b), .irq_req_in(irq_req), .wdt_req_in(wdt_req),
    .master_clear_pin_req_in(master_clear_pin_req), .irq_out(irq), .wdt_to_out(wdt_to), .master_clear_pin_b_out(master_clear_pin_b));
  swc_sleep_ctrl i_dut (.ref_clk_in(clk), .rst_b_in(rst_b), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_rdy), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(br),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rre), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .sleep_exec_in(slp), .pc_in(pcv),
    .master_clear_pin_b_in(master_clear_pin_b), .wdt_timeout_in(wdt_to), .irq_src_in(irq), .io_out_in(io_o),
    .io_oe_b_in(io_e), .io_out_out(io_oo), .io_oe_b_out(io_eo), .osc_drive_en_out(osc),
    .core_clk_en_out(cclk), .phase_clk_en_out(pclk), .wdt_clear_out(wclr), .full_reset_out(frst),
    .resume_out(res), .prefetch_addr_out(pfa), .pc_load_out(pld), .pc_value_out(pcval));
  task automatic fail(input string m);
    n_errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 64) begin
      fail("timeout");
      print_verdict();
    end
  endtask
  // outputs are read at the edge itself, so they show the cycle that just ended
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; bre <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) begin aw = 1'b1; awv <= 1'b0; end
      if (wv && wr_rdy) begin w = 1'b1; wv <= 1'b0; end
    end while (!(aw && w) && n < 64);
    do begin @(posedge clk); n++; end while (!bv && n < 64);
    tmo(n);
    chk(32'(br), 32'(er));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    arv <= 1'b1; ara <= a; rre <= 1'b1;
    do begin @(posedge clk); n++; end while (!arr && n < 64);
    arv <= 1'b0;
    do begin @(posedge clk); n++; end while (!rv && n < 64);
    tmo(n);
    chk(rd & m, ed);
    chk(32'(rr), 32'(er));
  endtask
  task automatic wait_ev(input int i, input logic [3:0] exp_ev);
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (!ev[i] && n < 64);
    tmo(n);
    chk(32'(ev), 32'(exp_ev));
  endtask
  task automatic quiet(input int c);
    logic [3:0] seen;
    seen = 4'h0;
    repeat (c) begin @(posedge clk); seen |= ev; end
    chk(32'(seen), 32'h0);
  endtask
  task automatic fire(input logic [3:0] m, input logic w, input logic mc);
    irq_req <= m; wdt_req <= w; master_clear_pin_req <= mc;
    @(posedge clk);
    irq_req <= 4'h0; wdt_req <= 1'b0; master_clear_pin_req <= 1'b0;
  endtask
  task automatic do_sleep(input logic [12:0] pc);
    pcv <= pc; slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset();
    axi_wr(a_st, 32'h0, ok);
    axi_rd(a_st, 32'h19, 32'h18, ok);
    chk(32'({osc, cclk, pclk}), 32'h7);
    axi_rd(8'h0C, 32'hFFFFFFFF, 32'h0, se);
    axi_wr(8'h0C, 32'hFF, se);
    axi_wr(a_ct, 32'hA5, ok);
    axi_rd(a_ct, 32'hFF, 32'hA5, ok);
    $display("test reset done");
  endtask
  task automatic t_noop();
    axi_wr(a_ct, 32'h05, ok);
    fire(4'h1, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    do_sleep(13'h0060);
    chk(32'({wclr, cclk}), 32'h1);
    quiet(4);
    axi_rd(a_st, 32'h19, 32'h18, ok);
    axi_wr(a_fl, 32'hF, ok);
    axi_rd(a_fl, 32'hF, 32'h0, ok);
    $display("test pending no-op done");
  endtask
  task automatic t_wdt();
    axi_wr(a_ct, 32'h01, ok);
    io_o <= 8'hA5; io_e <= 8'h0F;
    repeat (2) @(posedge clk);
    do_sleep(13'h0123);
    chk(32'(wclr), 32'h1);
    chk(32'({osc, cclk, pclk}), 32'h0);
    chk(32'(pfa), 32'h0124);
    io_o <= 8'h5A; io_e <= 8'hF0;
    axi_rd(a_st, 32'h19, 32'h11, ok);
    chk(32'({io_oo, io_eo}), 32'hA50F);
    quiet(8);
    fire(4'h0, 1'b1, 1'b0);
    wait_ev(1, 4'b0010);
    chk(32'(cclk), 32'h1);
    axi_rd(a_st, 32'h19, 32'h00, ok);
    $display("test watchdog wake done");
  endtask
  task automatic t_irq(input logic g);
    axi_wr(a_ct, {30'h1, g, 1'b0}, ok);
    do_sleep(13'h1FFF);
    chk(32'({wclr, pfa}), 32'h0);
    fire(4'h1, 1'b0, 1'b0);
    wait_ev(1, 4'b0010);
    @(posedge clk);
    chk(32'({pld, pcval}), g ? 32'h2004 : 32'h0);
    axi_rd(a_fl, 32'hF, 32'h1, ok);
    axi_rd(a_st, 32'h19, 32'h10, ok);
    axi_wr(a_fl, 32'hF, ok);
    $display("test interrupt wake done");
  endtask
  task automatic t_gate();
    axi_wr(a_ct, 32'h12, ok);
    do_sleep(13'h0040);
    fire(4'h5, 1'b0, 1'b0);
    quiet(8);
    axi_rd(a_fl, 32'h4, 32'h0, ok);
    fire(4'h0, 1'b0, 1'b1);
    wait_ev(3, 4'b1000);
    chk(32'(cclk), 32'h1);
    axi_wr(a_fl, 32'hF, ok);
    axi_wr(a_ct, 32'hA0, ok);
    do_sleep(13'h0050);
    fire(4'h8, 1'b0, 1'b0);
    wait_ev(1, 4'b0010);
    axi_wr(a_fl, 32'hF, ok);
    axi_wr(a_ct, 32'h58, ok);
    do_sleep(13'h0060);
    fire(4'h6, 1'b0, 1'b0);
    wait_ev(1, 4'b0010);
    axi_rd(a_fl, 32'hF, 32'h6, ok);
    axi_wr(a_fl, 32'hF, ok);
    $display("test source gating done");
  endtask
  task automatic t_race();
    axi_wr(a_ct, 32'h05, ok);
    irq_req <= 4'h1;
    @(posedge clk);
    irq_req <= 4'h0;
    do_sleep(13'h0070);
    chk(32'({wclr, cclk}), 32'h2);
    wait_ev(1, 4'b0010);
    axi_rd(a_st, 32'h19, 32'h10, ok);
    axi_wr(a_fl, 32'hF, ok);
    $display("test interrupt during sleep done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_noop();
    t_wdt();
    t_irq(1'b0);
    t_irq(1'b1);
    t_gate();
    t_race();
    print_verdict();
  end
endmodule // swc_sleep_ctrl_tb

// File: sim/swc_src_model.sv
// model of the wake sources: interrupt lines, watchdog and master clear pin
`timescale 1ns/1ps
module swc_src_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] irq_req_in,
  input wire logic wdt_req_in,
  input wire logic master_clear_pin_req_in,
  output swc_pkg::swc_irq_s irq_out,
  output logic wdt_to_out,
  output logic master_clear_pin_b_out
);
  logic [1:0] master_clear_pin_cnt_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out <= '0;
      wdt_to_out <= 1'b0;
      master_clear_pin_cnt_q <= 2'h0;
    end else begin
      irq_out <= irq_req_in;
      wdt_to_out <= wdt_req_in;
      master_clear_pin_cnt_q <= master_clear_pin_req_in ? 2'h3 : master_clear_pin_cnt_q - 2'(master_clear_pin_cnt_q != 2'h0);
    end
  end
  // pin held low for three cycles, so the press spans an asleep edge
  assign master_clear_pin_b_out = (master_clear_pin_cnt_q == 2'h0);
endmodule // swc_src_model
